/* File: hdl/tone_gate_pkg.sv */
// constants for the lnb tone gating control block
// assumes a single 20 mhz reference clock; no register bus
package tone_gate_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned EXT_ON_NS       = 1000;    // start after detect
  localparam int unsigned EXT_OFF_NS      = 60000;   // stop after last edge
  localparam int unsigned ENV_ON_NS       = 6000;    // envelope rise delay
  localparam int unsigned ENV_OFF_NS      = 30000;   // inside 15..60 us
  localparam int unsigned SS13_US         = 4000;    // 4 ms soft start
  localparam int unsigned SS18_US         = 6000;    // 6 ms soft start
  localparam int unsigned TONE_HZ         = 22000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1000000;
  localparam int unsigned EXT_ON_CYC  = (EXT_ON_NS * CYC_PER_US) / 1000;
  localparam int unsigned EXT_OFF_CYC = (EXT_OFF_NS * CYC_PER_US) / 1000;
  localparam int unsigned ENV_ON_CYC  = (ENV_ON_NS * CYC_PER_US) / 1000;
  localparam int unsigned ENV_OFF_CYC = (ENV_OFF_NS * CYC_PER_US) / 1000;
  localparam int unsigned SS13_CYC    = SS13_US * CYC_PER_US;
  localparam int unsigned SS18_CYC    = SS18_US * CYC_PER_US;
  localparam int unsigned HALF_TONE_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned CNT_W       = 18;
  localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;
endpackage : tone_gate_pkg

/* File: hdl/tone_delay.sv */
// delay counter: loads on start, pulses done when it reaches the target
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module tone_delay (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_nrst,
  input  wire logic                           i_start,
  input  wire logic                           i_abort,
  input  wire logic [tone_gate_pkg::CNT_W-1:0] i_target,
  output logic                                o_done
);
  logic [tone_gate_pkg::CNT_W-1:0] count;
  logic                            run;
  wire                             hit = run && (count >= i_target);

  // counts only while armed; abort wins so a cancelled delay never fires
  // a restart on the expiry cycle re-arms instead of silently stopping
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count  <= tone_gate_pkg::CNT_RST;
      run    <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= hit && !i_abort && !i_start;
      if (i_abort) begin
        run <= 1'b0;
      end else if (i_start) begin
        run   <= 1'b1;
        count <= 18'h00002;  // two cycles spent in start and done regs
      end else if (hit) begin
        run <= 1'b0;
      end else if (run) begin
        count <= count + 18'h00001;
      end
    end
  end
endmodule : tone_delay

/* File: hdl/lnb_tone_gating_control.sv */
// lnb tone gating control: decides when the internal tone or the keying waveform drives the output
// assumes control bits come from a host register stage on this clock and
// the keying input and supply-good level come from pins
//
// What this block and its host must do
// R1: external waveform gates tone when both bits set
// R2: envelope mode emits tone while keying high
// R3: continuous tone: keying high, tone bit switches
// R4: host keeps low-dissipation off during tone
// R5: low-dissipation applies only with tone disabled
// R6: external mode follows keying frequency and duty
// R7: external mode starts tone about 1 us
// R8: external mode stops tone 60 us later
// R9: host sets both bits before waveform
// R10: undervoltage disables every function
// R11: soft start ramps 4 ms or 6 ms
// R12: envelope mode: on 6 us, off 15-60 us
// R13: host frames keying with tone bit
// R14: tone bit off means no output tone
`timescale 1ns/1ps
module lnb_tone_gating_control (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_tone_keying_input,       // pin, async
  input  wire logic i_external_waveform_select,
  input  wire logic i_tone_on_bit,
  input  wire logic i_low_dissipation_bit,
  input  wire logic i_high_voltage_select,     // 1 selects 18 v level
  input  wire logic i_supply_good,             // pin, low under lockout
  output logic      o_lnb_supply_output_en,    // regulator enabled
  output logic      o_soft_start_done,         // ramp finished
  output logic      o_lnb_supply_tone,         // tone waveform to output
  output logic      o_tone_active,             // tone gate open
  output logic      o_low_dissipation_active   // reduced drop engaged
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic key_s1, key_s2, key_d, pg_s1, pg_s2;

  // first stages feed only second stages
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
      key_d  <= 1'b0;
      pg_s1  <= 1'b0;
      pg_s2  <= 1'b0;
    end else begin
      key_s1 <= i_tone_keying_input;
      key_s2 <= key_s1;
      key_d  <= key_s2;
      pg_s1  <= i_supply_good;
      pg_s2  <= pg_s1;
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  wire alive     = pg_s2;                                // R10
  wire key_edge  = key_s2 ^ key_d;
  wire mode_ext  = i_tone_on_bit && i_external_waveform_select;  // R1
  wire mode_env  = i_tone_on_bit && !i_external_waveform_select; // R2 R3

  // ------------------------------------------------------------
  // soft start ramp
  // ------------------------------------------------------------
  logic [tone_gate_pkg::CNT_W-1:0] ss_count;
  wire  [tone_gate_pkg::CNT_W-1:0] ss_target = i_high_voltage_select ?
      tone_gate_pkg::CNT_W'(tone_gate_pkg::SS18_CYC) :
      tone_gate_pkg::CNT_W'(tone_gate_pkg::SS13_CYC);
  wire ss_reached = ss_count >= ss_target;

  // lockout drops the regulator and restarts the ramp from zero
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ss_count               <= tone_gate_pkg::CNT_RST;
      o_soft_start_done      <= 1'b0;
      o_lnb_supply_output_en <= 1'b0;
    end else if (!alive) begin
      ss_count               <= tone_gate_pkg::CNT_RST;  // R10
      o_soft_start_done      <= 1'b0;
      o_lnb_supply_output_en <= 1'b0;
    end else begin
      o_lnb_supply_output_en <= 1'b1;
      o_soft_start_done      <= ss_reached;                // R11
      if (!ss_reached) begin
        ss_count <= ss_count + 18'h00001;                  // R11
      end
    end
  end

  // ------------------------------------------------------------
  // gating state machine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, ARMING, ON, HOLDING} gate_state_t;
  gate_state_t state, next_state;
  logic on_done, off_done;

  // an edge in external mode counts as detecting the waveform
  // envelope mode works on the level, so a pin already high still starts
  wire want_on  = alive && ((mode_ext && key_edge) || (mode_env && key_s2));
  wire keep_on  = alive && ((mode_ext && key_edge) || (mode_env && key_s2));
  wire drop_now = !alive || !i_tone_on_bit;                 // R14
  wire start_on  = (state == IDLE) && want_on && !drop_now;
  wire start_off = (state == ON) && !drop_now &&
                   ((mode_ext && !key_edge) || (mode_env && !key_s2));
  wire rearm     = (state == HOLDING) && keep_on && !drop_now;
  // a short envelope that ends while arming must not latch the tone on
  wire cancel_on = (state == ARMING) && mode_env && !key_s2;  // R12
  wire on_abort  = drop_now || cancel_on || (state != ARMING && !start_on);
  wire off_start = start_off || (state == HOLDING && mode_ext && key_edge);
  wire off_abort = drop_now || (state != HOLDING && !start_off) ||
                   (mode_env && rearm);

  wire [tone_gate_pkg::CNT_W-1:0] on_target = mode_ext ?
      tone_gate_pkg::CNT_W'(tone_gate_pkg::EXT_ON_CYC) :   // R7
      tone_gate_pkg::CNT_W'(tone_gate_pkg::ENV_ON_CYC);    // R12
  wire [tone_gate_pkg::CNT_W-1:0] off_target = mode_ext ?
      tone_gate_pkg::CNT_W'(tone_gate_pkg::EXT_OFF_CYC) :  // R8
      tone_gate_pkg::CNT_W'(tone_gate_pkg::ENV_OFF_CYC);   // R12

  // on timer arms from idle and is dropped outside arming
  tone_delay u_on_delay (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_start   (start_on),
    .i_abort   (on_abort),
    .i_target  (on_target),
    .o_done    (on_done)
  );

  // off timer restarts while waveform edges keep arriving
  tone_delay u_off_delay (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_start   (off_start),
    .i_abort   (off_abort),
    .i_target  (off_target),
    .o_done    (off_done)
  );

  // next state: lockout or a cleared tone bit always wins
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (start_on) begin
          next_state = ARMING;
        end
      end
      ARMING: begin
        if (drop_now || cancel_on) begin
          next_state = IDLE;
        end else if (on_done) begin
          next_state = ON;
        end
      end
      ON: begin
        if (drop_now) begin
          next_state = IDLE;
        end else if (start_off) begin
          next_state = HOLDING;
        end
      end
      HOLDING: begin
        if (drop_now) begin
          next_state = IDLE;
        end else if (mode_env && rearm) begin
          next_state = ON;
        end else if (off_done) begin
          next_state = IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // internal tone generator and output gating
  // ------------------------------------------------------------
  logic [9:0] tone_div;
  logic       tone_sq;
  wire        gate_open = (next_state == ON) || (next_state == HOLDING);

  // free running square wave; external mode copies keying shape instead
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tone_div <= 10'h000;
      tone_sq  <= 1'b0;
    end else if (tone_div == 10'(tone_gate_pkg::HALF_TONE_CYC - 1)) begin
      tone_div <= 10'h000;
      tone_sq  <= !tone_sq;
    end else begin
      tone_div <= tone_div + 10'h001;
    end
  end

  // registered outputs: the gate also waits for soft start to finish
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tone_active            <= 1'b0;
      o_lnb_supply_tone        <= 1'b0;
      o_low_dissipation_active <= 1'b0;
    end else begin
      o_tone_active     <= gate_open && o_soft_start_done;
      o_lnb_supply_tone <= gate_open && o_soft_start_done &&
                           (mode_ext ? key_s2 : tone_sq);   // R6 R14
      // reduced drop only while no tone can be produced
      o_low_dissipation_active <= alive && i_low_dissipation_bit &&
                                  !i_tone_on_bit && !gate_open; // R5 R4
    end
  end
endmodule : lnb_tone_gating_control

/* File: sim/tone_keying_source.sv */
// keying source model: demodulator side of the tone keying pin
// assumes the bench clock; changes only on the falling edge
`timescale 1ns/1ps
module tone_keying_source (
  input  wire logic i_ref_clk,
  input  wire logic i_burst,  // send the 22 khz waveform
  input  wire logic i_env,    // envelope level outside bursts
  output logic      o_tone_keying_input
);
  int unsigned half_cnt = 0;
  logic        wave     = 1'b1;
  wire         flip     = half_cnt == tone_gate_pkg::HALF_TONE_CYC - 1;
  // starts high so the burst opens with an edge at once
  always @(negedge i_ref_clk) begin
    half_cnt <= (!i_burst || flip) ? 0 : half_cnt + 1;
    wave     <= !i_burst ? 1'b1 : wave ^ flip;
  end
  assign o_tone_keying_input = i_burst ? wave : i_env;
endmodule : tone_keying_source

/* File: sim/lnb_tone_gating_control_properties.sv */
// port checker for the tone gating block, bound into it
// assumes one clock domain and keying driven clear of the clock edge
`timescale 1ns/1ps
module tone_gate_checker (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_tone_keying_input,
  input wire logic i_external_waveform_select,
  input wire logic i_tone_on_bit,
  input wire logic i_low_dissipation_bit,
  input wire logic i_high_voltage_select,
  input wire logic i_supply_good,
  input wire logic o_lnb_supply_output_en,
  input wire logic o_soft_start_done,
  input wire logic o_lnb_supply_tone,
  input wire logic o_tone_active,
  input wire logic o_low_dissipation_active
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic [7:0]  hi_cnt;
  logic [10:0] quiet_cnt;
  logic        key_q;
  wire env_run = !i_external_waveform_select && i_tone_on_bit &&
                 i_tone_keying_input && o_soft_start_done;
  wire moved = i_tone_keying_input != key_q;
  // counters saturate so a long hold never wraps into a false match
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_cnt    <= 8'h00;
      quiet_cnt <= 11'h000;
      key_q     <= 1'b0;
    end else begin
      hi_cnt    <= !env_run ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
      quiet_cnt <= (moved || !i_tone_on_bit) ? 11'h000 :
                   quiet_cnt + {10'h000, quiet_cnt != 11'h7ff};
      key_q     <= i_tone_keying_input;
    end
  end
  sequence seq_ext_start;
    i_external_waveform_select && i_tone_on_bit && o_soft_start_done &&
    quiet_cnt == 11'h7ff && moved;
  endsequence
  chk_no_tone_bit: assert property (!i_tone_on_bit |=> !o_tone_active)
    else $error("tone gate open with tone bit clear");
  chk_lockout_off: assert property (!i_supply_good [*4] |->
    !o_lnb_supply_output_en && !o_tone_active)
    else $error("output alive under lockout");
  chk_ss_first: assert property (o_tone_active |-> o_soft_start_done)
    else $error("tone before soft start done");
  chk_lowdiss_tone: assert property ((i_tone_on_bit || o_tone_active)
    |=> !o_low_dissipation_active)
    else $error("reduced drop with tone enabled");
  chk_gate_closed: assert property (!o_tone_active [*4] |->
    !o_lnb_supply_tone)
    else $error("tone waveform with gate closed");
  chk_env_early: assert property ((hi_cnt == 8'h01 && !o_tone_active)
    |-> ##100 !o_tone_active)
    else $error("envelope tone started too soon");
  chk_env_late: assert property (hi_cnt == 8'h82 |-> o_tone_active)
    else $error("envelope tone not started");
  chk_quiet_off: assert property ((quiet_cnt == 11'h4c4 &&
    (i_external_waveform_select || !i_tone_keying_input)) |-> !o_tone_active)
    else $error("tone still on after keying ended");
  chk_ext_start: assert property (seq_ext_start |->
    ##[16:30] o_tone_active)
    else $error("external waveform tone late");
endmodule : tone_gate_checker
bind lnb_tone_gating_control tone_gate_checker u_chk (.*);

/* File: sim/test_lnb_tone_gating_control.sv */
// self-checking bench for the tone gating block
// assumes the keying source model and the bound checker
`timescale 1ns/1ps
module test_lnb_tone_gating_control;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_tone_keying_input;
  logic i_external_waveform_select = 1'b0, i_tone_on_bit = 1'b0;
  logic i_low_dissipation_bit = 1'b0, i_high_voltage_select = 1'b0;
  logic i_supply_good = 1'b1, burst = 1'b0, env = 1'b0;
  logic o_lnb_supply_output_en, o_soft_start_done, o_lnb_supply_tone;
  logic o_tone_active, o_low_dissipation_active;
  int   n_fail = 0, total_checks = 0, n;
  // expected timings in clock cycles, from the package
  localparam int SS13 = tone_gate_pkg::SS13_CYC;
  localparam int EON  = tone_gate_pkg::ENV_ON_CYC;
  localparam int EOFF = tone_gate_pkg::ENV_OFF_CYC;
  localparam int XON  = tone_gate_pkg::EXT_ON_CYC;
  localparam int XOFF = tone_gate_pkg::EXT_OFF_CYC;
  localparam int HALF = tone_gate_pkg::HALF_TONE_CYC;
  always #25 i_ref_clk = ~i_ref_clk;
  lnb_tone_gating_control u_dut (.*);
  tone_keying_source u_src (.i_ref_clk, .i_burst(burst), .i_env(env),
    .o_tone_keying_input(i_tone_keying_input));
  function automatic logic in_win(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction : in_win
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // counts falling edges until the chosen signal shows want; bounded
  task automatic wait_for(input int sel, input logic want, input int lim,
                          output int cyc);
    cyc = 0;
    while ((sel == 1 ? o_soft_start_done : sel == 2 ? o_lnb_supply_tone :
            sel == 3 ? i_tone_keying_input : o_tone_active) !== want) begin
      @(negedge i_ref_clk);
      cyc++;
      if (cyc > lim) begin
        n_fail++;
        report_and_stop();
      end
    end
  endtask : wait_for
  initial begin
    void'($urandom(32'h940abb20));
    repeat (8) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    wait_for(1, 1'b1, 90000, n);
    check(in_win(n, SS13 - 8, SS13 + 8), 1'b1);
    check(o_lnb_supply_output_en, 1'b1);
    $display("soft start test done");
    env = 1'b1;
    i_low_dissipation_bit = 1'b1;
    repeat (200) @(negedge i_ref_clk);
    check(o_low_dissipation_active, 1'b1);
    check(o_tone_active, 1'b0);
    env = 1'b0;
    i_low_dissipation_bit = 1'b0;
    i_tone_on_bit = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    for (int k = 0; k < 3; k++) begin
      env = 1'b1;
      wait_for(0, 1'b1, 400, n);
      check(in_win(n, EON, EON + 6), 1'b1);
      repeat ($urandom_range(400, 50)) @(negedge i_ref_clk);
      env = 1'b0;
      wait_for(0, 1'b0, 1300, n);
      check(in_win(n, EOFF, EOFF + 6), 1'b1);
    end
    $display("envelope test done");
    env = 1'b1;
    wait_for(0, 1'b1, 400, n);
    wait_for(2, !o_lnb_supply_tone, 1000, n);
    wait_for(2, !o_lnb_supply_tone, 1000, n);
    check(in_win(n, HALF - 1, HALF + 1), 1'b1);
    i_tone_on_bit = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    check(o_tone_active, 1'b0);
    // keying still high: the tone bit alone must bring the tone back
    i_tone_on_bit = 1'b1;
    wait_for(0, 1'b1, 400, n);
    check(in_win(n, EON, EON + 6), 1'b1);
    i_tone_on_bit = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    check(o_tone_active, 1'b0);
    $display("continuous tone test done");
    // drop keying with the tone bit clear so no stray edge is seen
    env = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    i_tone_on_bit = 1'b1;
    i_external_waveform_select = 1'b1;
    repeat (2100) @(negedge i_ref_clk);
    burst = 1'b1;
    wait_for(0, 1'b1, 100, n);
    check(in_win(n, XON, XON + 6), 1'b1);
    repeat (4) begin
      wait_for(3, !i_tone_keying_input, 1000, n);
      repeat (100) @(negedge i_ref_clk);
      check(o_lnb_supply_tone, i_tone_keying_input);
    end
    wait_for(3, 1'b1, 1000, n);
    burst = 1'b0;
    wait_for(0, 1'b0, 1400, n);
    check(in_win(n, XOFF, XOFF + 8), 1'b1);
    burst = 1'b1;
    wait_for(0, 1'b1, 100, n);
    i_tone_on_bit = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    check(o_tone_active, 1'b0);
    $display("external waveform test done");
    burst = 1'b0;
    i_external_waveform_select = 1'b0;
    // ramp time so far is under 6 ms, so the 18 v level is not yet reached
    i_high_voltage_select = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    check(o_soft_start_done, 1'b0);
    i_high_voltage_select = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    check(o_soft_start_done, 1'b1);
    $display("voltage select test done");
    i_tone_on_bit = 1'b1;
    env = 1'b1;
    wait_for(0, 1'b1, 400, n);
    i_supply_good = 1'b0;
    repeat (5) @(negedge i_ref_clk);
    check({o_lnb_supply_output_en, o_tone_active}, 2'b00);
    $display("lockout test done");
    report_and_stop();
  end
endmodule : test_lnb_tone_gating_control
